// [rtl/rss_pkg.sv]
// Constants and types shared by the site survey indicator
package rss_pkg;

  // ----------------------------------------------------------------
  // Widths and address range
  // ----------------------------------------------------------------
  localparam int ADDR_W = 6;
  localparam int DIGIT_W = 4;
  localparam int GRADE_W = 2;
  localparam int NUM_GRADES = 4;
  localparam int CNT_W = 16;
  localparam int TIMER_W = 40;
  localparam int TICK_W = 24;
  localparam int PHASE_W = 4;
  localparam int NODE_MAX = 47;
  localparam logic [DIGIT_W-1:0] TENS_MAX = 4'h4;
  localparam logic [DIGIT_W-1:0] ONES_MAX = 4'h9;
  localparam logic [7:0] TENS_WEIGHT = 8'h0a;
  localparam logic [ADDR_W-1:0] ADDR_MIN = 6'h01;
  localparam logic [ADDR_W-1:0] ADDR_MAX = 6'h2f;

  // ----------------------------------------------------------------
  // Signal strength grades
  // ----------------------------------------------------------------
  localparam logic [GRADE_W-1:0] GRADE_WEAK = 2'h0;
  localparam logic [GRADE_W-1:0] GRADE_GOOD = 2'h1;
  localparam logic [GRADE_W-1:0] GRADE_STRONG = 2'h2;
  localparam logic [GRADE_W-1:0] GRADE_VSTRONG = 2'h3;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam longint unsigned CLK_HZ = 64'd100_000_000;
  localparam longint unsigned TIMEOUT_S = 64'd900;
  localparam longint unsigned TIMEOUT_CYC = TIMEOUT_S * CLK_HZ;
  // Base tick at 16 Hz: one phase bit toggling per tick gives 8 flashes/s
  localparam longint unsigned TICK_HZ = 64'd16;
  localparam longint unsigned TICK_CYC = CLK_HZ / TICK_HZ;

  // ----------------------------------------------------------------
  // Reset, step and saturation values
  // ----------------------------------------------------------------
  localparam logic [CNT_W-1:0] CNT_ZERO = 16'h0000;
  localparam logic [CNT_W-1:0] CNT_ONE = 16'h0001;
  localparam logic [CNT_W-1:0] CNT_SAT = 16'hffff;
  localparam logic [TIMER_W-1:0] TIMER_ZERO = 40'h00_0000_0000;
  localparam logic [TIMER_W-1:0] TIMER_ONE = 40'h00_0000_0001;
  localparam logic [TICK_W-1:0] TICK_ZERO = 24'h00_0000;
  localparam logic [TICK_W-1:0] TICK_ONE = 24'h00_0001;
  localparam logic [PHASE_W-1:0] PHASE_ZERO = 4'h0;
  localparam logic [PHASE_W-1:0] PHASE_ONE = 4'h1;

  typedef enum logic [1:0] {
    RSS_NORMAL,
    RSS_SURVEY,
    RSS_EXPIRED
  } rss_state_t;

endpackage : rss_pkg

// [rtl/rss_survey_indicator.sv]
// Site survey controller and bi-colour indicator driver for the gateway
`timescale 1ns/1ps

module rss_survey_indicator import rss_pkg::*; #(
  parameter longint unsigned TIMEOUT_CYCLES = TIMEOUT_CYC,
  parameter longint unsigned TICK_CYCLES = TICK_CYC
) (
  input wire logic mclk_i,
  input wire logic reset_i,
  input wire logic [DIGIT_W-1:0] sel_tens_i,
  input wire logic [DIGIT_W-1:0] sel_ones_i,
  input wire logic [NODE_MAX:0] node_present_i,
  input wire logic rx_valid_i,
  input wire logic rx_retry_i,
  input wire logic [ADDR_W-1:0] rx_addr_i,
  input wire logic [GRADE_W-1:0] rx_grade_i,
  output logic survey_active_o,
  output logic [ADDR_W-1:0] survey_addr_o,
  output logic [GRADE_W-1:0] grade_o,
  output logic [CNT_W-1:0] packet_count_o,
  output logic [CNT_W-1:0] retry_count_o,
  output logic led_red_o,
  output logic led_green_o
);

  // ----------------------------------------------------------------
  // Selector decoding
  // ----------------------------------------------------------------
  function automatic logic [ADDR_W-1:0] dial_addr(input logic [DIGIT_W-1:0] tens,
                                                   input logic [DIGIT_W-1:0] ones);
    logic [7:0] sum;
    sum = 8'(tens) * TENS_WEIGHT + 8'(ones);
    return sum[ADDR_W-1:0];
  endfunction : dial_addr

  function automatic logic dial_valid(input logic [DIGIT_W-1:0] tens,
                                      input logic [DIGIT_W-1:0] ones);
    logic [ADDR_W-1:0] a;
    a = dial_addr(tens, ones);
    return (tens <= TENS_MAX) && (ones <= ONES_MAX) && (a >= ADDR_MIN) && (a <= ADDR_MAX);
  endfunction : dial_valid

  logic sel_nonzero;
  logic sel_changed;
  logic [ADDR_W-1:0] sel_addr;
  logic sel_ok;

  assign sel_nonzero = (sel_tens_i != 4'h0) || (sel_ones_i != 4'h0);
  assign sel_addr = dial_addr(sel_tens_i, sel_ones_i);
  assign sel_ok = dial_valid(sel_tens_i, sel_ones_i);

  // ----------------------------------------------------------------
  // Common time base
  // ----------------------------------------------------------------
  // One divider feeds every flash rate so the rates stay phase-locked
  logic [TICK_W-1:0] tick_cnt;
  logic [TICK_W-1:0] next_tick_cnt;
  logic [PHASE_W-1:0] phase;
  logic [PHASE_W-1:0] next_phase;
  logic tick;

  assign tick = (tick_cnt == TICK_W'(TICK_CYCLES - 64'd1));

  always_comb begin
    next_tick_cnt = tick ? TICK_ZERO : tick_cnt + TICK_ONE;
    next_phase = tick ? phase + PHASE_ONE : phase;
  end

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      tick_cnt <= TICK_ZERO;
      phase <= PHASE_ZERO;
    end else begin
      tick_cnt <= next_tick_cnt;
      phase <= next_phase;
    end
  end

  // ----------------------------------------------------------------
  // Survey sequencing
  // ----------------------------------------------------------------
  rss_state_t state;
  rss_state_t next_state;
  logic [DIGIT_W-1:0] cur_tens;
  logic [DIGIT_W-1:0] next_cur_tens;
  logic [DIGIT_W-1:0] cur_ones;
  logic [DIGIT_W-1:0] next_cur_ones;
  logic [ADDR_W-1:0] addr;
  logic [ADDR_W-1:0] next_addr;
  logic addr_ok;
  logic next_addr_ok;
  logic [TIMER_W-1:0] timer;
  logic [TIMER_W-1:0] next_timer;
  logic start;
  logic timeout;

  assign sel_changed = (sel_tens_i != cur_tens) || (sel_ones_i != cur_ones);
  assign timeout = (timer == TIMER_W'(TIMEOUT_CYCLES - 64'd1));

  always_comb begin
    next_state = state;
    start = 1'b0;
    case (state)
      RSS_NORMAL: begin
        if (sel_nonzero) begin
          next_state = RSS_SURVEY;
          start = 1'b1;
        end
      end
      RSS_SURVEY: begin
        if (!sel_nonzero) begin
          next_state = RSS_NORMAL;
        end else if (sel_changed) begin
          start = 1'b1;
        end else if (timeout) begin
          next_state = RSS_EXPIRED;
        end
      end
      RSS_EXPIRED: begin
        // Stale dial setting must not relaunch; only a fresh choice does
        if (!sel_nonzero) begin
          next_state = RSS_NORMAL;
        end else if (sel_changed) begin
          next_state = RSS_SURVEY;
          start = 1'b1;
        end
      end
      default: begin
        next_state = RSS_NORMAL;
      end
    endcase
    next_cur_tens = start ? sel_tens_i : cur_tens;
    next_cur_ones = start ? sel_ones_i : cur_ones;
    next_addr = start ? sel_addr : addr;
    next_addr_ok = start ? sel_ok : addr_ok;
    if (start) begin
      next_timer = TIMER_ZERO;
    end else if (state == RSS_SURVEY) begin
      next_timer = timer + TIMER_ONE;
    end else begin
      next_timer = timer;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      state <= RSS_NORMAL;
      cur_tens <= 4'h0;
      cur_ones <= 4'h0;
      addr <= 6'h00;
      addr_ok <= 1'b0;
      timer <= TIMER_ZERO;
    end else begin
      state <= next_state;
      cur_tens <= next_cur_tens;
      cur_ones <= next_cur_ones;
      addr <= next_addr;
      addr_ok <= next_addr_ok;
      timer <= next_timer;
    end
  end

  // ----------------------------------------------------------------
  // Packet statistics
  // ----------------------------------------------------------------
  logic [CNT_W-1:0] grade_cnt [NUM_GRADES];
  logic [CNT_W-1:0] next_grade_cnt [NUM_GRADES];
  logic [CNT_W-1:0] pkt_cnt;
  logic [CNT_W-1:0] next_pkt_cnt;
  logic [CNT_W-1:0] retry_cnt;
  logic [CNT_W-1:0] next_retry_cnt;
  logic [GRADE_W-1:0] grade;
  logic [GRADE_W-1:0] next_grade;
  logic [CNT_W-1:0] best_cnt;
  logic ours;

  // Counters saturate rather than wrap so a long survey loses the lead grade only if a weaker grade also saturates
  assign ours = (state == RSS_SURVEY) && addr_ok && !start && (rx_addr_i == addr);

  genvar g;
  generate
    for (g = 0; g < NUM_GRADES; g++) begin : g_grade
      always_comb begin
        if (start) begin
          next_grade_cnt[g] = CNT_ZERO;
        end else if (ours && rx_valid_i && (rx_grade_i == GRADE_W'(g)) &&
                     (grade_cnt[g] != CNT_SAT)) begin
          next_grade_cnt[g] = grade_cnt[g] + CNT_ONE;
        end else begin
          next_grade_cnt[g] = grade_cnt[g];
        end
      end

      always_ff @(posedge mclk_i) begin
        if (reset_i) begin
          grade_cnt[g] <= CNT_ZERO;
        end else begin
          grade_cnt[g] <= next_grade_cnt[g];
        end
      end
    end
  endgenerate

  always_comb begin
    if (start) begin
      next_pkt_cnt = CNT_ZERO;
      next_retry_cnt = CNT_ZERO;
    end else begin
      next_pkt_cnt = (ours && rx_valid_i && (pkt_cnt != CNT_SAT)) ? pkt_cnt + CNT_ONE : pkt_cnt;
      next_retry_cnt = (ours && rx_retry_i && (retry_cnt != CNT_SAT)) ?
                       retry_cnt + CNT_ONE : retry_cnt;
    end
    // Ties resolve to the weaker grade: the report never flatters the link
    next_grade = GRADE_WEAK;
    best_cnt = grade_cnt[0];
    for (int i = 1; i < NUM_GRADES; i++) begin
      if (grade_cnt[i] > best_cnt) begin
        next_grade = GRADE_W'(i);
        best_cnt = grade_cnt[i];
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      pkt_cnt <= CNT_ZERO;
      retry_cnt <= CNT_ZERO;
      grade <= GRADE_WEAK;
    end else begin
      pkt_cnt <= next_pkt_cnt;
      retry_cnt <= next_retry_cnt;
      grade <= next_grade;
    end
  end

  // ----------------------------------------------------------------
  // Indicator
  // ----------------------------------------------------------------
  logic next_red;
  logic next_green;
  logic flash;
  logic present;

  assign present = addr_ok && node_present_i[addr];

  always_comb begin
    case (grade)
      GRADE_VSTRONG: flash = phase[0];
      GRADE_STRONG: flash = phase[1];
      GRADE_GOOD: flash = phase[2];
      default: flash = phase[3];
    endcase
    if (state != RSS_SURVEY) begin
      next_red = 1'b0;
      next_green = phase[PHASE_W-1];
    end else if (!present) begin
      next_red = 1'b1;
      next_green = 1'b0;
    end else if (pkt_cnt == CNT_ZERO) begin
      next_red = 1'b1;
      next_green = 1'b1;
    end else begin
      next_red = flash;
      next_green = flash;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      led_red_o <= 1'b0;
      led_green_o <= 1'b0;
    end else begin
      led_red_o <= next_red;
      led_green_o <= next_green;
    end
  end

  assign survey_active_o = (state == RSS_SURVEY);
  assign survey_addr_o = addr;
  assign grade_o = grade;
  assign packet_count_o = pkt_cnt;
  assign retry_count_o = retry_cnt;

endmodule : rss_survey_indicator

// [verif/rss_node_model.sv]
// Remote node model that sends packet events to the gateway
`timescale 1ns/1ps
module rss_node_model import rss_pkg::*; (
  input wire logic mclk_i,
  output logic rx_valid_o,
  output logic rx_retry_o,
  output logic [ADDR_W-1:0] rx_addr_o,
  output logic [GRADE_W-1:0] rx_grade_o
);
  initial begin
    rx_valid_o = 1'b0;
    rx_retry_o = 1'b0;
    rx_addr_o = 6'h3f;
    rx_grade_o = 2'h0;
  end
  // Idle lines carry the inverse so a stale address never matches
  task automatic send(input logic [ADDR_W-1:0] a, input logic [GRADE_W-1:0] g,
                      input logic v, input logic r, input int gap);
    @(negedge mclk_i);
    rx_valid_o = v;
    rx_retry_o = r;
    rx_addr_o = a;
    rx_grade_o = g;
    @(negedge mclk_i);
    rx_valid_o = 1'b0;
    rx_retry_o = 1'b0;
    rx_addr_o = ~a;
    rx_grade_o = ~g;
    repeat (gap) @(negedge mclk_i);
  endtask : send
endmodule : rss_node_model

// [verif/rss_survey_indicator_asserts.sv]
// Checker for the site survey indicator ports
`timescale 1ns/1ps
module rss_survey_indicator_asserts import rss_pkg::*; #(
  parameter longint unsigned TIMEOUT_CYCLES = TIMEOUT_CYC,
  parameter longint unsigned TICK_CYCLES = TICK_CYC
) (
  input wire logic mclk_i,
  input wire logic reset_i,
  input wire logic [DIGIT_W-1:0] sel_tens_i,
  input wire logic [DIGIT_W-1:0] sel_ones_i,
  input wire logic [NODE_MAX:0] node_present_i,
  input wire logic rx_valid_i,
  input wire logic rx_retry_i,
  input wire logic [ADDR_W-1:0] rx_addr_i,
  input wire logic survey_active_o,
  input wire logic [ADDR_W-1:0] survey_addr_o,
  input wire logic [CNT_W-1:0] packet_count_o,
  input wire logic [CNT_W-1:0] retry_count_o,
  input wire logic led_red_o,
  input wire logic led_green_o
);
  logic [7:0] dial;
  logic [7:0] dial_q;
  logic ok;
  logic here;
  logic hit;
  logic [TIMER_W-1:0] run;
  logic [TIMER_W-1:0] next_run;
  assign dial = sel_tens_i * TENS_WEIGHT + 8'(sel_ones_i);
  assign ok = sel_tens_i <= TENS_MAX && sel_ones_i <= ONES_MAX && dial != 0 && dial <= 8'h2f;
  assign here = survey_addr_o <= ADDR_MAX && node_present_i[survey_addr_o];
  assign hit = ok && here && survey_active_o && rx_addr_i == survey_addr_o;
  // Run length of one unbroken survey; a dial change restarts it
  always_comb begin
    next_run = (!survey_active_o || dial != dial_q) ? TIMER_ZERO : run + TIMER_ONE;
  end
  always_ff @(posedge mclk_i) begin
    dial_q <= reset_i ? 8'h00 : dial;
    run <= reset_i ? TIMER_ZERO : next_run;
  end
  default clocking @(posedge mclk_i); endclocking
  default disable iff (reset_i);
  sequence s_new_sel;
    ok && !$stable(dial);
  endsequence
  a_start_dials: assert property (s_new_sel |=> survey_active_o)
    else $error("survey did not start");
  a_addr_load: assert property (s_new_sel |=> survey_addr_o == dial[5:0] &&
    packet_count_o == CNT_ZERO && retry_count_o == CNT_ZERO) else $error("bad restart");
  a_zero_exit: assert property (dial == 8'h00 |=> !survey_active_o)
    else $error("survey kept at 00");
  a_pkt_count: assert property (
    hit && $stable(dial) && rx_valid_i && packet_count_o != CNT_SAT
    |=> packet_count_o == $past(packet_count_o) + CNT_ONE) else $error("packet lost");
  a_retry_count: assert property (
    hit && $stable(dial) && rx_retry_i && retry_count_o != CNT_SAT
    |=> retry_count_o == $past(retry_count_o) + CNT_ONE) else $error("retry lost");
  a_absent_red: assert property (
    (survey_active_o && !here) [*2] |=> led_red_o && !led_green_o)
    else $error("absent node not red");
  a_amber_idle: assert property (
    (survey_active_o && here && packet_count_o == CNT_ZERO) [*2]
    |=> led_red_o && led_green_o) else $error("idle not amber");
  a_normal_dark: assert property (!survey_active_o [*2] |=> !led_red_o)
    else $error("red lit outside survey");
  a_timeout_cap: assert property (run <= TIMEOUT_CYCLES)
    else $error("survey outlived timeout");
endmodule : rss_survey_indicator_asserts
bind rss_survey_indicator rss_survey_indicator_asserts #(.TIMEOUT_CYCLES(TIMEOUT_CYCLES),
  .TICK_CYCLES(TICK_CYCLES)) i_chk (.*);

// [verif/rss_survey_indicator_tb_top.sv]
// Self-checking bench for the site survey indicator
`timescale 1ns/1ps
module rss_survey_indicator_tb_top import rss_pkg::*; ;
  // Short counts keep the run small
  localparam int TO = 200;
  localparam int TK = 4;
  logic mclk_i = 1'b0;
  logic reset_i = 1'b1;
  logic [DIGIT_W-1:0] tens = 4'h0;
  logic [DIGIT_W-1:0] ones = 4'h0;
  logic [NODE_MAX:0] present;
  logic rx_valid, rx_retry, act, red, green;
  logic [ADDR_W-1:0] rx_addr, saddr;
  logic [GRADE_W-1:0] rx_grade, grade;
  logic [CNT_W-1:0] pcnt, rcnt;
  int fails = 0;
  int cmp_count = 0;
  int hist[4], pk, rt, sel, node, g, b;
  always #5 mclk_i = ~mclk_i;
  rss_node_model i_node (.mclk_i(mclk_i), .rx_valid_o(rx_valid), .rx_retry_o(rx_retry),
    .rx_addr_o(rx_addr), .rx_grade_o(rx_grade));
  rss_survey_indicator #(.TIMEOUT_CYCLES(TO), .TICK_CYCLES(TK)) i_dut (.mclk_i(mclk_i),
    .reset_i(reset_i), .sel_tens_i(tens), .sel_ones_i(ones), .node_present_i(present),
    .rx_valid_i(rx_valid), .rx_retry_i(rx_retry), .rx_addr_i(rx_addr), .rx_grade_i(rx_grade),
    .survey_active_o(act), .survey_addr_o(saddr), .grade_o(grade), .packet_count_o(pcnt),
    .retry_count_o(rcnt), .led_red_o(red), .led_green_o(green));
  task automatic check(input string what, input logic [CNT_W-1:0] seen, input int exp);
    cmp_count++;
    if (seen !== CNT_W'(exp)) begin
      fails++;
      $display("BAD %s exp %0h seen %0h", what, exp, seen);
    end
  endtask : check
  task automatic end_of_test;
    $display("checks %0d fails %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : end_of_test
  // New selection also clears the model statistics
  task automatic dial(input int a);
    @(negedge mclk_i);
    tens = 4'(a / 10);
    ones = 4'(a % 10);
    sel = a;
    pk = 0;
    rt = 0;
    hist = '{default: 0};
    repeat (3) @(negedge mclk_i);
  endtask : dial
  task automatic pkt(input int a, input int gr, input logic v, input logic r);
    i_node.send(6'(a), 2'(gr), v, r, $urandom % 3);
    // Packets from the surveyed address count whether or not the node map lists it
    if (a == sel && v) begin
      hist[gr]++;
      pk++;
    end
    if (a == sel && r) rt++;
  endtask : pkt
  task automatic flashes(input int exp, input logic amb);
    int n;
    logic p;
    n = 0;
    p = green;
    repeat (128) begin
      @(negedge mclk_i);
      check("red", red, amb & green);
      n += (green !== p);
      p = green;
    end
    check("flashes", n, exp);
  endtask : flashes
  initial begin
    repeat (20000) @(negedge mclk_i);
    fails++;
    end_of_test;
  end
  initial begin
    void'($urandom(32'hd628f426));
    present = 48'({$urandom, $urandom});
    node = 4 + $urandom % 44;
    present[2] = 1'b0;
    present[node] = 1'b1;
    present[node-1] = 1'b1;
    repeat (5) @(negedge mclk_i);
    reset_i = 1'b0;
    check("act", act, 0);
    check("led", {red, green}, 0);
    // Phase leaves reset at zero; one cycle on, the window spans four whole green edges
    @(negedge mclk_i);
    flashes(4, 1'b0);
    dial(2);
    check("act", act, 1);
    check("addr", saddr, 2);
    check("led", {red, green}, 2);
    pkt(2, 3, 1'b1, 1'b0);
    check("pcnt", pcnt, pk);
    check("led", {red, green}, 2);
    dial(node);
    check("addr", saddr, node);
    check("led", {red, green}, 3);
    for (g = 0; g < 4; g++) begin
      dial(node - g % 2);
      pkt(sel, g, 1'b1, 1'b1);
      repeat (4) pkt(sel, g, 1'b1, 1'b0);
      repeat (2) pkt(sel, $urandom % 4, 1'b1, 1'b0);
      pkt(node - 1 + g % 2, 3, 1'b1, 1'b1);
      repeat (4) @(negedge mclk_i);
      b = 0;
      for (int k = 1; k < 4; k++) if (hist[k] > hist[b]) b = k;
      check("pcnt", pcnt, pk);
      check("rcnt", rcnt, rt);
      check("grade", grade, b);
      flashes(32 >> (3 - g), 1'b1);
    end
    dial(0);
    check("act", act, 0);
    flashes(4, 1'b0);
    dial(node);
    repeat (150) @(negedge mclk_i);
    dial(node - 1);
    repeat (150) @(negedge mclk_i);
    check("act", act, 1);
    repeat (60) @(negedge mclk_i);
    check("act", act, 0);
    repeat (5) @(negedge mclk_i);
    check("act", act, 0);
    dial(node);
    check("act", act, 1);
    check("addr", saddr, node);
    end_of_test;
  end
endmodule : rss_survey_indicator_tb_top
